// ==== rtl/qu_channel.sv ====
// One serial channel: host registers, holding FIFOs, serializer, receiver and interrupt logic.
`timescale 1ns/1ps
`include "qu_params.svh"
module qu_channel
   import qu_pkg::*;
(
   input  wire logic       clk_sys,      // 250 MHz system clock
   input  wire logic       rst,          // async reset, active high
   input  wire logic [2:0] bus_addr,     // register address
   input  wire logic [7:0] bus_wdata,    // write data
   input  wire logic       bus_wr,       // write strobe, one cycle
   input  wire logic       bus_rd,       // read strobe, one cycle
   output logic      [7:0] bus_rdata,    // read data, registered
   input  wire logic       bus_mode_68,  // 1 selects shared interrupt request
   input  wire logic       rxd,          // serial receive line
   output logic            txd,          // serial transmit line
   input  wire logic       cts,          // clear to send, high asserted
   output logic            rts,          // request to send
   output logic            irq_chan,     // channel interrupt, high asserted
   output logic            irq_wor_out,  // shared request drive value
   output logic            irq_wor_oe_n, // shared request enable, low drives
   output logic            sleep_mode    // channel asleep
);
   logic [7:0]  interrupt_mask, fifo_control_reg, line_control_reg, mcr, spr, enhanced_feature_reg, xon1, xon2, xoff1, xoff2;
   logic [15:0] divisor, baud_cnt;
   logic        tick;
   logic        dlab, enh;
   logic        wr_data, wr_gen, rd_rhr, rd_lsr, rd_msr, rd_isr;
   logic [7:0]  next_rdata;
   logic [5:0]  isr_code;
   logic        fifo_on;
   // Transmit path.
   logic        txf_in_ready, txf_out_valid, tx_load;
   logic [7:0]  txf_out_data;
   logic [5:0]  txf_level;
   qu_tx_state_t tx_state;
   logic [3:0]  tx_tick;
   logic [2:0]  tx_bit;
   logic [7:0]  tx_shift;
   logic        tx_par, tx_stop2nd;
   logic        thr_room, thr_empty, all_empty;
   // Receive path.
   qu_rx_state_t rx_state;
   logic        rx_prev;
   logic [3:0]  rx_tick;
   logic [2:0]  rx_bit;
   logic [7:0]  rx_shift, rx_char;
   logic        rx_perr, rx_push;
   logic [10:0] rx_word;
   logic        rxf_in_ready, rxf_out_valid;
   logic [10:0] rxf_out_data;
   logic [5:0]  rxf_level, rx_trig;
   // Status and interrupt state.
   logic        overrun, fifo_err, rls_pend, msr_pend, xoff_pend, cts_pend, rts_pend;
   logic        cts_prev, rts_prev;
   logic        rxd_pend, thr_pend, any_irq;

   assign dlab    = line_control_reg[`QU_LCR_DLAB];
   assign enh     = (line_control_reg == `QU_LCR_ENH);
   assign fifo_on = fifo_control_reg[`QU_FCR_EN];
   assign wr_gen  = bus_wr && !dlab;
   assign wr_data = bus_wr && (bus_addr == `QU_ADR_DATA) && !dlab;
   assign rd_rhr  = bus_rd && (bus_addr == `QU_ADR_DATA) && !dlab;
   assign rd_isr  = bus_rd && (bus_addr == `QU_ADR_FIFO) && !dlab;
   assign rd_lsr  = bus_rd && (bus_addr == `QU_ADR_LSR) && !dlab;
   assign rd_msr  = bus_rd && (bus_addr == `QU_ADR_MSR) && !dlab;

   // Divisor of zero stops the 16x tick, as an unprogrammed rate generator would.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         baud_cnt <= 16'h0000;
         tick     <= 1'b0;
      end
      else
      begin
         tick <= 1'b0;
         if (divisor != 16'h0000)
         begin
            if (baud_cnt >= divisor - 16'h0001)
            begin
               baud_cnt <= 16'h0000;
               tick     <= 1'b1;
            end
            else
               baud_cnt <= baud_cnt + 16'h0001;
         end
      end
   end

   // Control register writes.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         interrupt_mask     <= `QU_RST_IER;
         fifo_control_reg     <= `QU_RST_FCR;
         line_control_reg     <= `QU_RST_LCR;
         mcr     <= `QU_RST_MCR;
         spr     <= `QU_RST_SPR;
         enhanced_feature_reg     <= `QU_RST_EFR;
         xon1    <= `QU_RST_XCHR;
         xon2    <= `QU_RST_XCHR;
         xoff1   <= `QU_RST_XCHR;
         xoff2   <= `QU_RST_XCHR;
         divisor <= `QU_RST_DIV;
      end
      else if (bus_wr)
      begin
         fifo_control_reg[`QU_FCR_RXRST] <= 1'b0;
         fifo_control_reg[`QU_FCR_TXRST] <= 1'b0;
         case (bus_addr)
            `QU_ADR_DATA:
               if (dlab)
                  divisor[7:0] <= bus_wdata;
            `QU_ADR_IER:
               if (dlab)
                  divisor[15:8] <= bus_wdata;
               else if (enhanced_feature_reg[`QU_EFR_ENH])
                  interrupt_mask <= bus_wdata;
               else
                  interrupt_mask[3:0] <= bus_wdata[3:0];
            `QU_ADR_FIFO:
               if (enh)
                  enhanced_feature_reg <= bus_wdata;
               else if (wr_gen)
                  fifo_control_reg <= bus_wdata;
            `QU_ADR_LCR:
               line_control_reg <= bus_wdata;
            `QU_ADR_MCR:
               if (enh)
                  xon1 <= bus_wdata;
               else if (wr_gen)
                  mcr <= bus_wdata;
            `QU_ADR_LSR:
               if (enh)
                  xon2 <= bus_wdata;
            `QU_ADR_MSR:
               if (enh)
                  xoff1 <= bus_wdata;
            `QU_ADR_SPR:
               if (enh)
                  xoff2 <= bus_wdata;
               else if (wr_gen)
                  spr <= bus_wdata;
            default:
               spr <= spr;
         endcase
      end
      else
      begin
         fifo_control_reg[`QU_FCR_RXRST] <= 1'b0;
         fifo_control_reg[`QU_FCR_TXRST] <= 1'b0;
      end
   end

   // Without FIFO mode only one character is held on each side.
   assign thr_room  = fifo_on ? txf_in_ready : (txf_level == 6'h00);
   assign thr_empty = thr_room;
   assign all_empty = (txf_level == 6'h00) && (tx_state == QU_TX_IDLE);
   assign tx_load   = tick && (tx_state == QU_TX_IDLE) && txf_out_valid;

   qu_fifo #(.WIDTH(8), .DEPTH(`QU_FIFO_DEPTH)) u_txf (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .flush     (fifo_control_reg[`QU_FCR_TXRST]),
      .in_valid  (wr_data && thr_room),
      .in_ready  (txf_in_ready),
      .in_data   (bus_wdata),
      .out_valid (txf_out_valid),
      .out_ready (tx_load),
      .out_data  (txf_out_data),
      .level     (txf_level)
   );

   // Serializer: each bit lasts 16 ticks.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         tx_state   <= QU_TX_IDLE;
         tx_tick    <= 4'h0;
         tx_bit     <= 3'h0;
         tx_shift   <= 8'h00;
         tx_par     <= 1'b0;
         tx_stop2nd <= 1'b0;
      end
      else if (tick)
      begin
         tx_tick <= tx_tick + 4'h1;
         case (tx_state)
            QU_TX_IDLE:
               if (txf_out_valid)
               begin
                  tx_shift <= txf_out_data;
                  tx_par   <= qu_par_bit(txf_out_data, line_control_reg);
                  tx_state <= QU_TX_START;
                  tx_tick  <= 4'h0;
               end
            QU_TX_START:
               if (tx_tick == `QU_BIT_TICKS_END)
               begin
                  tx_state <= QU_TX_DATA;
                  tx_bit   <= 3'h0;
               end
            QU_TX_DATA:
               if (tx_tick == `QU_BIT_TICKS_END)
               begin
                  tx_shift <= {1'b0, tx_shift[7:1]};
                  tx_bit   <= tx_bit + 3'h1;
                  if (tx_bit == {1'b1, line_control_reg[1:0]})
                     tx_state <= line_control_reg[`QU_LCR_PEN] ? QU_TX_PAR : QU_TX_STOP;
                  tx_stop2nd <= 1'b0;
               end
            QU_TX_PAR:
               if (tx_tick == `QU_BIT_TICKS_END)
                  tx_state <= QU_TX_STOP;
            QU_TX_STOP:
               if (tx_tick == `QU_BIT_TICKS_END)
               begin
                  if (line_control_reg[`QU_LCR_STOP2] && !tx_stop2nd)
                     tx_stop2nd <= 1'b1;
                  else
                     tx_state <= QU_TX_IDLE;
               end
            default:
               tx_state <= QU_TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         txd <= 1'b1;
      else if (line_control_reg[`QU_LCR_BREAK])
         txd <= 1'b0;
      else
         case (tx_state)
            QU_TX_START: txd <= 1'b0;
            QU_TX_DATA:  txd <= tx_shift[0];
            QU_TX_PAR:   txd <= tx_par;
            default:     txd <= 1'b1;
         endcase
   end

   // Receiver: a falling edge starts the count; the line is checked at mid start bit.
   assign rx_char = rx_shift >> (2'h3 - line_control_reg[1:0]);

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rx_state <= QU_RX_IDLE;
         rx_prev  <= 1'b1;
         rx_tick  <= 4'h0;
         rx_bit   <= 3'h0;
         rx_shift <= 8'h00;
         rx_perr  <= 1'b0;
         rx_push  <= 1'b0;
         rx_word  <= 11'h000;
      end
      else
      begin
         rx_prev <= rxd;
         rx_push <= 1'b0;
         if (rx_state == QU_RX_IDLE)
         begin
            if (rx_prev && !rxd)
            begin
               rx_state <= QU_RX_START;
               rx_tick  <= 4'h0;
            end
         end
         else if (tick)
         begin
            rx_tick <= rx_tick + 4'h1;
            case (rx_state)
               QU_RX_START:
                  if (rx_tick == `QU_START_SAMPLE)
                  begin
                     rx_state <= rxd ? QU_RX_IDLE : QU_RX_DATA;
                     rx_tick  <= 4'h0;
                     rx_bit   <= 3'h0;
                     rx_perr  <= 1'b0;
                  end
               QU_RX_DATA:
                  if (rx_tick == `QU_BIT_TICKS_END)
                  begin
                     rx_shift <= {rxd, rx_shift[7:1]};
                     rx_bit   <= rx_bit + 3'h1;
                     if (rx_bit == {1'b1, line_control_reg[1:0]})
                        rx_state <= line_control_reg[`QU_LCR_PEN] ? QU_RX_PAR : QU_RX_STOP;
                  end
               QU_RX_PAR:
                  if (rx_tick == `QU_BIT_TICKS_END)
                  begin
                     rx_perr  <= (rxd != qu_par_bit(rx_char, line_control_reg));
                     rx_state <= QU_RX_STOP;
                  end
               QU_RX_STOP:
                  if (rx_tick == `QU_BIT_TICKS_END)
                  begin
                     rx_word  <= {!rxd && (rx_char == 8'h00), !rxd, rx_perr, rx_char};
                     rx_push  <= 1'b1;
                     rx_state <= QU_RX_IDLE;
                  end
               default:
                  rx_state <= QU_RX_IDLE;
            endcase
         end
      end
   end

   qu_fifo #(.WIDTH(11), .DEPTH(`QU_FIFO_DEPTH)) u_rxf (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .flush     (fifo_control_reg[`QU_FCR_RXRST]),
      .in_valid  (rx_push && (fifo_on || rxf_level == 6'h00)),
      .in_ready  (rxf_in_ready),
      .in_data   (rx_word),
      .out_valid (rxf_out_valid),
      .out_ready (rd_rhr),
      .out_data  (rxf_out_data),
      .level     (rxf_level)
   );

   // Sticky status: a setting event always wins over a clearing read in the same cycle.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         overrun   <= 1'b0;
         fifo_err  <= 1'b0;
         rls_pend  <= 1'b0;
         msr_pend  <= 1'b0;
         xoff_pend <= 1'b0;
         cts_pend  <= 1'b0;
         rts_pend  <= 1'b0;
         cts_prev  <= 1'b0;
         rts_prev  <= 1'b0;
      end
      else
      begin
         cts_prev  <= cts;
         rts_prev  <= rts;
         overrun   <= (rx_push && !(rxf_in_ready && (fifo_on || rxf_level == 6'h00))) || (overrun && !rd_lsr);
         fifo_err  <= (rx_push && (rx_word[10:8] != 3'h0)) || (fifo_err && !rd_lsr);
         rls_pend  <= rx_push || (rls_pend && !rd_lsr);
         msr_pend  <= (cts != cts_prev) || (msr_pend && !rd_msr);
         xoff_pend <= (rx_push && rx_word[7:0] == xoff1) || (xoff_pend && !rd_isr);
         cts_pend  <= (cts && !cts_prev) || (cts_pend && !rd_isr);
         rts_pend  <= (rts && !rts_prev) || (rts_pend && !rd_isr);
      end
   end

   always_comb
   begin
      case (fifo_control_reg[7:6])
         2'h0:    rx_trig = `QU_RXTRIG_0;
         2'h1:    rx_trig = `QU_RXTRIG_1;
         2'h2:    rx_trig = `QU_RXTRIG_2;
         default: rx_trig = `QU_RXTRIG_3;
      endcase
   end

   // Clearing mask bits 0 to 3 leaves these sources visible only in line status and modem status (polled use).
   assign rxd_pend = interrupt_mask[`QU_IE_RXD] && (fifo_on ? (rxf_level >= rx_trig) : rxf_out_valid);
   assign thr_pend = interrupt_mask[`QU_IE_THR] && thr_empty;
   assign any_irq  = (interrupt_mask[`QU_IE_RLS] && rls_pend) || rxd_pend || thr_pend
                     || (interrupt_mask[`QU_IE_MSR] && msr_pend) || (interrupt_mask[`QU_IE_XOFF] && xoff_pend)
                     || (interrupt_mask[`QU_IE_CTS] && cts_pend) || (interrupt_mask[`QU_IE_RTS] && rts_pend);

   always_comb
   begin
      if (interrupt_mask[`QU_IE_RLS] && rls_pend)
         isr_code = `QU_ISR_RLS;
      else if (rxd_pend)
         isr_code = `QU_ISR_RXD;
      else if (thr_pend)
         isr_code = `QU_ISR_THR;
      else if (interrupt_mask[`QU_IE_MSR] && msr_pend)
         isr_code = `QU_ISR_MSR;
      else if (interrupt_mask[`QU_IE_XOFF] && xoff_pend)
         isr_code = `QU_ISR_XOFF;
      else if ((interrupt_mask[`QU_IE_CTS] && cts_pend) || (interrupt_mask[`QU_IE_RTS] && rts_pend))
         isr_code = `QU_ISR_CTSRTS;
      else
         isr_code = `QU_ISR_NONE;
   end

   always_comb
   begin
      next_rdata = 8'h00;
      case (bus_addr)
         `QU_ADR_DATA: next_rdata = dlab ? divisor[7:0] : rxf_out_data[7:0];
         `QU_ADR_IER:  next_rdata = dlab ? divisor[15:8] : interrupt_mask;
         `QU_ADR_FIFO: next_rdata = enh ? enhanced_feature_reg : (dlab ? 8'h00 : {fifo_on, fifo_on, isr_code});
         `QU_ADR_LCR:  next_rdata = line_control_reg;
         `QU_ADR_MCR:  next_rdata = enh ? xon1 : (dlab ? 8'h00 : mcr);
         `QU_ADR_LSR:  next_rdata = enh ? xon2 : (dlab ? 8'h00 :
                                    {fifo_err, all_empty, thr_empty,
                                     rxf_out_valid ? rxf_out_data[10:8] : 3'h0, overrun, rxf_out_valid});
         `QU_ADR_MSR:  next_rdata = enh ? xoff1 : (dlab ? 8'h00 : {3'h0, cts, 3'h0, msr_pend});
         `QU_ADR_SPR:  next_rdata = enh ? xoff2 : (dlab ? 8'h00 : spr);
         default:      next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         bus_rdata <= 8'h00;
      else if (bus_rd)
         bus_rdata <= next_rdata;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         irq_chan     <= 1'b0;
         irq_wor_out  <= 1'b0;
         irq_wor_oe_n <= 1'b1;
         rts          <= 1'b0;
         sleep_mode   <= 1'b0;
      end
      else
      begin
         irq_chan     <= any_irq && !bus_mode_68;
         irq_wor_oe_n <= !(any_irq && bus_mode_68);
         rts          <= mcr[`QU_MCR_RTS];
         sleep_mode   <= interrupt_mask[`QU_IE_SLEEP] && all_empty && !any_irq
                         && (rx_state == QU_RX_IDLE) && (rxf_level == 6'h00);
      end
   end
endmodule // qu_channel

// ==== rtl/qu_fifo.sv ====
// First-word-fall-through FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module qu_fifo import qu_pkg::*; #(parameter int WIDTH = 8, parameter int DEPTH = 32)
(
   input  wire logic                     clk_sys,   // system clock
   input  wire logic                     rst,       // async reset
   input  wire logic                     flush,     // empty the FIFO
   input  wire logic                     in_valid,  // write request
   output logic                          in_ready,  // room available
   input  wire logic [WIDTH-1:0]         in_data,   // write data
   output logic                          out_valid, // head word valid
   input  wire logic                     out_ready, // consumer takes head
   output logic      [WIDTH-1:0]         out_data,  // head word
   output logic      [$clog2(DEPTH):0]   level      // words held
);
   localparam int AW = $clog2(DEPTH);
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic          fresh;
   logic          push;
   logic          pop;

   assign in_ready  = (level != DEPTH[AW:0]);
   assign out_valid = (level != '0) && !fresh;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // The read port is registered, so a word written at the head address is not visible for one cycle.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level  <= '0;
         fresh  <= 1'b0;
      end
      else if (flush)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level  <= '0;
         fresh  <= 1'b0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         level <= level + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
         fresh <= push && (wr_ptr == (rd_ptr + {{(AW-1){1'b0}}, pop}));
      end
   end

   qu_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
      .clk_sys (clk_sys),
      .wr_en   (push),
      .wr_addr (wr_ptr),
      .wr_data (in_data),
      .rd_addr (rd_ptr + {{(AW-1){1'b0}}, pop}),
      .rd_data (out_data)
   );
endmodule // qu_fifo

// ==== rtl/qu_mem.sv ====
// Small dual-port storage with registered read data.
`timescale 1ns/1ps
module qu_mem import qu_pkg::*; #(parameter int WIDTH = 8, parameter int DEPTH = 32, parameter int AW = 5)
(
   input  wire logic             clk_sys,  // system clock
   input  wire logic             wr_en,    // write strobe
   input  wire logic [AW-1:0]    wr_addr,  // write address
   input  wire logic [WIDTH-1:0] wr_data,  // write data
   input  wire logic [AW-1:0]    rd_addr,  // read address
   output logic      [WIDTH-1:0] rd_data   // registered read data
);
   logic [WIDTH-1:0] store [DEPTH];

   always_ff @(posedge clk_sys)
   begin
      if (wr_en)
         store[wr_addr] <= wr_data;
   end

   always_ff @(posedge clk_sys)
   begin
      rd_data <= store[rd_addr];
   end
endmodule // qu_mem

// ==== rtl/qu_params.svh ====
// Register offsets, field positions, reset values and counts for one serial channel.
`ifndef QU_PARAMS_SVH
`define QU_PARAMS_SVH
`define QU_ADR_DATA 3'h0
`define QU_ADR_IER 3'h1
`define QU_ADR_FIFO 3'h2
`define QU_ADR_LCR 3'h3
`define QU_ADR_MCR 3'h4
`define QU_ADR_LSR 3'h5
`define QU_ADR_MSR 3'h6
`define QU_ADR_SPR 3'h7
`define QU_LCR_DLAB 7
`define QU_LCR_BREAK 6
`define QU_LCR_STICK 5
`define QU_LCR_EVEN 4
`define QU_LCR_PEN 3
`define QU_LCR_STOP2 2
`define QU_LCR_ENH 8'hBF
`define QU_IE_RXD 0
`define QU_IE_THR 1
`define QU_IE_RLS 2
`define QU_IE_MSR 3
`define QU_IE_SLEEP 4
`define QU_IE_XOFF 5
`define QU_IE_RTS 6
`define QU_IE_CTS 7
`define QU_EFR_ENH 4
`define QU_FCR_EN 0
`define QU_FCR_RXRST 1
`define QU_FCR_TXRST 2
`define QU_MCR_RTS 1
`define QU_RST_IER 8'h00
`define QU_RST_FCR 8'h00
`define QU_RST_LCR 8'h00
`define QU_RST_MCR 8'h00
`define QU_RST_SPR 8'hFF
`define QU_RST_EFR 8'h00
`define QU_RST_XCHR 8'h00
`define QU_RST_DIV 16'h0001
`define QU_ISR_NONE 6'h01
`define QU_ISR_RLS 6'h06
`define QU_ISR_RXD 6'h04
`define QU_ISR_THR 6'h02
`define QU_ISR_MSR 6'h00
`define QU_ISR_XOFF 6'h10
`define QU_ISR_CTSRTS 6'h20
`define QU_START_SAMPLE 4'h7
`define QU_BIT_TICKS_END 4'hF
`define QU_RXTRIG_0 6'h08
`define QU_RXTRIG_1 6'h10
`define QU_RXTRIG_2 6'h18
`define QU_RXTRIG_3 6'h1C
`define QU_FIFO_DEPTH 32
`endif

// ==== rtl/qu_pkg.sv ====
// Types and shared helpers for the serial channel.
package qu_pkg;
   typedef enum logic [2:0] {
      QU_RX_IDLE  = 3'b000,
      QU_RX_START = 3'b001,
      QU_RX_DATA  = 3'b010,
      QU_RX_PAR   = 3'b011,
      QU_RX_STOP  = 3'b100
   } qu_rx_state_t;
   typedef enum logic [2:0] {
      QU_TX_IDLE  = 3'b000,
      QU_TX_START = 3'b001,
      QU_TX_DATA  = 3'b010,
      QU_TX_PAR   = 3'b011,
      QU_TX_STOP  = 3'b100
   } qu_tx_state_t;
   // Parity bit for a character of 5 to 8 bits under the line control settings.
   function automatic logic qu_par_bit(input logic [7:0] d, input logic [7:0] line_control_reg);
      logic [7:0] m;
      m = d & (8'hFF >> (2'h3 - line_control_reg[1:0]));
      if (line_control_reg[5])
         qu_par_bit = ~line_control_reg[4];
      else
         qu_par_bit = (^m) ^ ~line_control_reg[4];
   endfunction
endpackage

// ==== testbench/qu_chan_properties.sv ====
// Port-level properties of one serial channel.
`timescale 1ns/1ps
module qu_chan_properties (
   input wire logic       clk_sys, rst, bus_wr, bus_rd, bus_mode_68, rxd, cts, // inputs
   input wire logic [2:0] bus_addr,                                            // register address
   input wire logic [7:0] bus_wdata, bus_rdata,                                // bus data
   input wire logic       txd, rts, irq_chan, irq_wor_out, irq_wor_oe_n, sleep_mode // outputs
);
   // Sticky and coarse on purpose: it only has to say when no source can be enabled.
   logic ier_on;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   always_ff @(posedge clk_sys or posedge rst)
      if (rst)
         ier_on <= 1'b0;
      else if (bus_wr && bus_addr == 3'h1 && bus_wdata != 8'h00)
         ier_on <= 1'b1;
   AST_WOR_ZERO: assert property (irq_wor_out == 1'b0) else $error("shared drive not low");
   AST_M68_CHAN: assert property (bus_mode_68 |=> !irq_chan) else $error("channel irq in 68 mode");
   AST_M16_WOR: assert property (!bus_mode_68 |=> irq_wor_oe_n) else $error("shared irq in 16 mode");
   AST_ONE_PIN: assert property (!(irq_chan && !irq_wor_oe_n)) else $error("irq on both pins");
   AST_RST_VAL: assert property (disable iff (1'b0) rst ##1 rst |-> !irq_chan && irq_wor_oe_n && !sleep_mode && txd)
      else $error("outputs not at reset level");
   AST_RD_HOLD: assert property (!bus_rd |=> $stable(bus_rdata)) else $error("read data moved");
   AST_SLEEP_IDLE: assert property (sleep_mode |-> txd) else $error("asleep while sending");
   AST_MASK_QUIET: assert property (!ier_on |-> !irq_chan && irq_wor_oe_n) else $error("irq with mask clear");
endmodule // qu_chan_properties

// ==== testbench/qu_line_peer.sv ====
// Serial line peer: a loopback cable that can also pull the line low.
`timescale 1ns/1ps
module qu_line_peer (
   input  wire logic txd,    // channel transmit line
   input  wire logic glitch, // forces the line low
   output logic      rxd     // channel receive line
);
   assign rxd = txd & ~glitch;
endmodule // qu_line_peer

// ==== testbench/tb.sv ====
// Bench for one serial channel on its host bus, line looped back.
`timescale 1ns/1ps
`define CHK(a, b) begin ev = 8'(b); comparisons++; if ((a) !== ev) begin n_fail++; $display("[ERR] %0t got %h exp %h", $time, a, ev); end end
module tb;
   logic       clk_sys = 1'b0;
   logic       rst = 1'b1;
   logic       bus_wr, bus_rd, bus_mode_68, rxd, txd, cts, rts, glitch, seen;
   logic       irq_chan, irq_wor_out, irq_wor_oe_n, sleep_mode;
   logic [2:0] bus_addr;
   logic [7:0] bus_wdata, bus_rdata, ev;
   logic [7:0] lf = 8'h4A;
   logic [7:0] lr;
   logic [7:0] q[$];
   int         n_fail = 0;
   int         comparisons = 0;
   qu_channel qu_channel_inst (.*);
   qu_line_peer qu_line_peer_inst (.*);
   function automatic logic [7:0] nxt(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic c(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // A read notes its expected byte; the monitor checks it one cycle later, on the next falling edge.
   task automatic x(input bit rd, input int a, input int d);
      c(1);
      {bus_rd, bus_wr, bus_addr, bus_wdata} = {rd, !rd, 3'(a), 8'(d)};
      if (rd) q.push_back(8'(d));
      c(1);
      {bus_rd, bus_wr} = 2'b00;
   endtask
   task automatic complete_run;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial forever #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) seen <= bus_rd;
   always @(negedge clk_sys) if (seen === 1'b1) `CHK(bus_rdata, q.pop_front())
   initial
   begin
      c(20000);
      n_fail++;
      complete_run;
   end
   initial
   begin
      {bus_wr, bus_rd, bus_mode_68, cts, glitch, bus_addr, bus_wdata} = '0;
      c(16);
      rst = 1'b0;
      x(1, 1, 'h00);
      x(1, 5, 'h60);
      x(0, 3, 'h80);
      x(1, 0, 'h01);
      x(1, 4, 'h00);
      x(0, 3, 'hBF);
      x(0, 2, 'h10);
      x(0, 6, nxt(lf));
      x(1, 6, nxt(lf));
      x(0, 3, 'h03);
      x(0, 2, 'h01);
      x(0, 1, 'h04);
      x(0, 0, nxt(nxt(lf)));
      x(0, 0, nxt(nxt(nxt(lf))));
      // Two full frames at divisor 1 take 320 cycles.
      c(400);
      `CHK(irq_chan, 1'b1)
      x(1, 5, 'h61);
      x(1, 0, nxt(nxt(lf)));
      x(1, 0, nxt(nxt(nxt(lf))));
      x(1, 5, 'h60);
      // The first random byte was stored as the first Xoff character, so looping it back must flag it.
      x(0, 1, 'h20);
      x(0, 0, nxt(lf));
      c(200);
      `CHK(irq_chan, 1'b1)
      x(1, 2, 'hD0);
      x(1, 5, 'h61);
      x(1, 0, nxt(lf));
      bus_mode_68 = 1'b1;
      x(0, 1, 'h02);
      c(3);
      `CHK({irq_chan, irq_wor_oe_n}, 2'b00)
      bus_mode_68 = 1'b0;
      c(2);
      `CHK(irq_chan, 1'b1)
      x(0, 1, 'h04);
      glitch = 1'b1;
      c(4);
      glitch = 1'b0;
      c(300);
      `CHK(irq_chan, 1'b0)
      x(0, 1, 'h10);
      c(4);
      `CHK(sleep_mode, 1'b1)
      `CHK(irq_chan, 1'b0)
      x(1, 5, 'h60);
      x(0, 1, 'h40);
      x(0, 4, 'h02);
      c(3);
      `CHK(rts, 1'b1)
      x(1, 2, 'hE0);
      x(0, 1, 'h80);
      cts = 1'b1;
      c(4);
      `CHK(irq_chan, 1'b1)
      x(1, 2, 'hE0);
      c(2);
      `CHK(irq_chan, 1'b0)
      // Eight characters with odd parity and two stop bits reach the lowest receive trigger.
      x(0, 1, 'h01);
      x(0, 3, 'h0F);
      lr = lf;
      repeat (8)
      begin
         lf = nxt(lf);
         x(0, 0, lf);
      end
      c(1700);
      `CHK(irq_chan, 1'b1)
      x(1, 2, 'hC4);
      lr = nxt(lr);
      x(1, 0, lr);
      c(2);
      `CHK(irq_chan, 1'b0)
      x(1, 2, 'hC1);
      repeat (7)
      begin
         lr = nxt(lr);
         x(1, 0, lr);
      end
      // A held break comes back as one zero character with break and framing errors.
      x(0, 3, 'h43);
      c(200);
      x(0, 3, 'h03);
      x(1, 5, 'hF9);
      x(1, 0, 'h00);
      x(1, 5, 'h60);
      x(0, 2, 'h00);
      x(0, 1, 'h08);
      x(1, 6, 'h11);
      c(2);
      `CHK(irq_chan, 1'b0)
      cts = 1'b0;
      c(4);
      `CHK(irq_chan, 1'b1)
      x(1, 2, 'h00);
      x(1, 6, 'h01);
      c(2);
      `CHK(irq_chan, 1'b0)
      complete_run;
   end
endmodule // tb
bind qu_channel qu_chan_properties qu_chan_properties_inst (.*);
